// [rtl/copper_irq_pkg.sv]
package copper_irq_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_ENABLE = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h13;
  localparam logic [5:0] IDX_SUMMARY = 6'h17;
  localparam logic [5:0] IDX_CLEAR = 6'h1A;
  localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [REG_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [REG_W-1:0] RESERVED_MASK = 16'h00A4;
  // status bit positions
  localparam int BIT_AN_ERROR = 15;
  localparam int BIT_SPEED = 14;
  localparam int BIT_DUPLEX = 13;
  localparam int BIT_PAGE = 12;
  localparam int BIT_AN_DONE = 11;
  localparam int BIT_LINK = 10;
  localparam int BIT_SYMBOL = 9;
  localparam int BIT_FALSE_CARRIER = 8;
  localparam int BIT_MDIX = 6;
  localparam int BIT_ENERGY = 4;
  localparam int BIT_FLP_NO_LINK = 3;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_JABBER = 0;
  localparam int BIT_SUMMARY = 0;
endpackage

// [rtl/copper_phy_event_interrupts.sv]
`timescale 1ns/1ns
module copper_phy_event_interrupts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [copper_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // software reset pulse from the core
  input wire logic soft_reset,
  // autonegotiation failure causes, one-cycle pulses
  input wire logic ms_resolve_fail,
  input wire logic parallel_detect_fault,
  input wire logic no_common_hcd,
  input wire logic link_fail_after_an,
  // negotiation and receive event pulses
  input wire logic page_received,
  input wire logic an_complete,
  input wire logic symbol_error,
  input wire logic false_carrier,
  input wire logic flp_done_no_link,
  // resolved levels watched for change
  input wire logic [1:0] resolved_speed,
  input wire logic resolved_duplex,
  input wire logic copper_link_up,
  input wire logic resolved_mdix,
  input wire logic energy_sleep,
  input wire logic polarity_reversed,
  // jabber level, latched while present
  input wire logic jabber_active,
  // port interrupt, level
  output logic irq
);
  import copper_irq_pkg::*;

  logic [REG_W-1:0] enable;
  logic [REG_W-1:0] next_enable;
  logic [31:0] next_prdata;
  logic [REG_W-1:0] rd_status;
  logic [REG_W-1:0] next_rd_status;
  logic [1:0] prev_speed;
  logic prev_duplex;
  logic prev_link;
  logic prev_mdix;
  logic prev_energy;
  logic prev_polarity;
  logic primed;
  logic [1:0] next_prev_speed;
  logic next_prev_duplex;
  logic next_prev_link;
  logic next_prev_mdix;
  logic next_prev_energy;
  logic next_prev_polarity;
  logic next_primed;
  logic [REG_W-1:0] events;
  logic [REG_W-1:0] wr_clear;
  logic setup_phase;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic mapped;
  logic pending;

  irq_latch_if #(.W(REG_W)) lat ();

  // apb decode; zero wait states, so every access ends in one cycle
  assign idx = paddr[7:2];
  assign setup_phase = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign mapped = (idx == IDX_ENABLE) || (idx == IDX_STATUS) ||
                  (idx == IDX_SUMMARY) || (idx == IDX_CLEAR);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // previous levels for change detection; primed stops a false edge at reset
  always_comb begin
    next_prev_speed = resolved_speed;
    next_prev_duplex = resolved_duplex;
    next_prev_link = copper_link_up;
    next_prev_mdix = resolved_mdix;
    next_prev_energy = energy_sleep;
    next_prev_polarity = polarity_reversed;
    next_primed = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_speed <= 2'h0;
      prev_duplex <= 1'b0;
      prev_link <= 1'b0;
      prev_mdix <= 1'b0;
      prev_energy <= 1'b0;
      prev_polarity <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev_speed <= next_prev_speed;
      prev_duplex <= next_prev_duplex;
      prev_link <= next_prev_link;
      prev_mdix <= next_prev_mdix;
      prev_energy <= next_prev_energy;
      prev_polarity <= next_prev_polarity;
      primed <= next_primed;
    end
  end

  // event vector, one position per status bit; reserved positions stay zero
  always_comb begin
    events = '0;
    events[BIT_AN_ERROR] = ms_resolve_fail || parallel_detect_fault ||
                           no_common_hcd || link_fail_after_an;
    events[BIT_SPEED] = primed && (resolved_speed != prev_speed);
    events[BIT_DUPLEX] = primed && (resolved_duplex != prev_duplex);
    events[BIT_PAGE] = page_received;
    events[BIT_AN_DONE] = an_complete;
    events[BIT_LINK] = primed && (copper_link_up != prev_link);
    events[BIT_SYMBOL] = symbol_error;
    events[BIT_FALSE_CARRIER] = false_carrier;
    events[BIT_MDIX] = primed && (resolved_mdix != prev_mdix);
    events[BIT_ENERGY] = primed && (energy_sleep != prev_energy);
    events[BIT_FLP_NO_LINK] = flp_done_no_link;
    events[BIT_POLARITY] = primed && (polarity_reversed != prev_polarity);
    events[BIT_JABBER] = jabber_active;
  end

  // explicit clear register: write one to drop a bit
  always_comb begin
    wr_clear = '0;
    if (wr_en && (idx == IDX_CLEAR)) begin
      wr_clear[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
      wr_clear[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
    end
  end

  // read clears reported
  // only bits captured for the read are cleared, so a later event is kept
  assign lat.set_ev = events;
  assign lat.clr = wr_clear | ((rd_en && (idx == IDX_STATUS)) ? rd_status : '0);
  assign lat.clear_all = soft_reset;

  event_latch #(.W(REG_W)) u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .lat(lat)
  );

  // enable register; survives software reset
  always_comb begin
    next_enable = enable;
    if (wr_en && (idx == IDX_ENABLE)) begin
      if (pstrb[0]) begin
        next_enable[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_enable[15:8] = pwdata[15:8];
      end
    end
    next_enable = next_enable & ~RESERVED_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= ENABLE_RST;
    end else begin
      enable <= next_enable;
    end
  end

  assign pending = |(lat.status & enable);
  assign irq = pending;

  // read data captured in the setup cycle, held through the access
  always_comb begin
    next_prdata = prdata;
    next_rd_status = rd_status;
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      next_rd_status = '0;
      if (!pwrite) begin
        unique case (idx)
          IDX_ENABLE: begin
            next_prdata[REG_W-1:0] = enable;
          end
          IDX_STATUS: begin
            next_prdata[REG_W-1:0] = lat.status;
            next_rd_status = lat.status;
          end
          IDX_SUMMARY: begin
            next_prdata[BIT_SUMMARY] = pending;
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_status <= STATUS_RST;
    end else begin
      prdata <= next_prdata;
      rd_status <= next_rd_status;
    end
  end
endmodule

// [rtl/event_latch.sv]
`timescale 1ns/1ns
module event_latch #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // latch control and state
  irq_latch_if.latch lat
);
  import copper_irq_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic bit_q;
      logic next_bit;
      // set beats clear so an event in the clearing cycle survives
      always_comb begin
        next_bit = bit_q;
        if (lat.clear_all || lat.clr[i]) begin
          next_bit = 1'b0;
        end
        if (lat.set_ev[i] && !RESERVED_MASK[i]) begin
          next_bit = 1'b1;
        end
        if (lat.clear_all && !lat.set_ev[i]) begin
          next_bit = 1'b0;
        end
      end
      // hardware reset clears every latch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bit_q <= STATUS_RST[i];
        end else begin
          bit_q <= next_bit;
        end
      end
      assign lat.status[i] = bit_q & ~RESERVED_MASK[i];
    end
  endgenerate
endmodule

// [rtl/irq_latch_if.sv]
`timescale 1ns/1ns
interface irq_latch_if #(parameter int W = 16);
  logic [W-1:0] set_ev;
  logic [W-1:0] clr;
  logic clear_all;
  logic [W-1:0] status;
  modport latch (input set_ev, input clr, input clear_all, output status);
  modport ctrl (output set_ev, output clr, output clear_all, input status);
endinterface

// [test/copper_irq_asserts.sv]
`timescale 1ns/1ns
module copper_irq_checker
  import copper_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  // events and interrupt
  input wire logic ms_resolve_fail,
  input wire logic parallel_detect_fault,
  input wire logic no_common_hcd,
  input wire logic link_fail_after_an,
  input wire logic page_received,
  input wire logic an_complete,
  input wire logic [1:0] resolved_speed,
  input wire logic copper_link_up,
  input wire logic jabber_active,
  input wire logic irq
);
  logic [15:0] en_q;
  logic [15:0] next_en_q;
  logic acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the enable register, reserved bits kept clear
  assign acc = psel && penable;
  always_comb begin
    next_en_q = en_q;
    if (acc && pwrite && paddr[7:2] == IDX_ENABLE) begin
      if (pstrb[0]) next_en_q[7:0] = pwdata[7:0];
      if (pstrb[1]) next_en_q[15:8] = pwdata[15:8];
    end
    next_en_q = next_en_q & ~RESERVED_MASK;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= '0;
    else en_q <= next_en_q;
  end
  en_block_a: assert property (en_q == '0 |-> !irq)
    else $error("irq while all enables clear");
  an_err_a: assert property ((ms_resolve_fail || parallel_detect_fault || no_common_hcd
    || link_fail_after_an) && en_q[15] |=> irq) else $error("an error missed");
  speed_chg_a: assert property ($changed(resolved_speed) && en_q[14] |-> ##[1:2] irq)
    else $error("speed change missed");
  page_rx_a: assert property (page_received && en_q[12] |=> irq)
    else $error("page event missed");
  an_done_a: assert property (an_complete && en_q[11] |=> irq)
    else $error("an done missed");
  link_chg_a: assert property ($changed(copper_link_up) && en_q[10] |-> ##[1:2] irq)
    else $error("link change missed");
  jabber_a: assert property (jabber_active && en_q[0] |=> irq)
    else $error("jabber missed");
  summary_a: assert property (acc && !pwrite && paddr[7:2] == IDX_SUMMARY
    |-> prdata[0] == $past(irq)) else $error("summary wrong");
  rsvd_zero_a: assert property (acc && !pwrite && paddr[7:2] == IDX_STATUS
    |-> (prdata[15:0] & RESERVED_MASK) == '0) else $error("reserved bit set");
endmodule
bind copper_phy_event_interrupts copper_irq_checker i_copper_irq_checker (.*);

// [test/copper_phy_event_interrupts_tb.sv]
`timescale 1ns/1ns
module copper_phy_event_interrupts_tb;
  import copper_irq_pkg::*;
  localparam logic [7:0] A_EN = {IDX_ENABLE, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_SUM = {IDX_SUMMARY, 2'b00};
  localparam logic [7:0] A_CLR = {IDX_CLEAR, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, slv;
  logic srst = 1'b0, pg = 1'b0, anc = 1'b0, sym = 1'b0, fc = 1'b0, flp = 1'b0, jab = 1'b0;
  logic dup = 1'b0, lnk = 1'b0, mdx = 1'b0, slp = 1'b0, pol = 1'b0;
  logic [3:0] anf = 4'h0;
  logic [1:0] spd = 2'h0;
  logic [15:0] q;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int bits [13] = '{15, 14, 13, 12, 11, 10, 9, 8, 6, 4, 3, 1, 0};
  always #25 pclk = ~pclk;
  copper_phy_event_interrupts i_copper_phy_event_interrupts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(srst), .ms_resolve_fail(anf[0]),
    .parallel_detect_fault(anf[1]), .no_common_hcd(anf[2]), .link_fail_after_an(anf[3]),
    .page_received(pg), .an_complete(anc), .symbol_error(sym), .false_carrier(fc),
    .flp_done_no_link(flp), .resolved_speed(spd), .resolved_duplex(dup),
    .copper_link_up(lnk), .resolved_mdix(mdx), .energy_sleep(slp),
    .polarity_reversed(pol), .jabber_active(jab), .irq(irq));
  task close_out();
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      close_out();
    end
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits on pready, no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the hang guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[15:0];
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // raise one event: pulses last a cycle, levels toggle
  task ev(input int b, input int k);
    @(posedge pclk);
    case (b)
      15: anf[k] <= 1'b1;
      14: spd <= spd + 2'h1;
      13: dup <= !dup;
      12: pg <= 1'b1;
      11: anc <= 1'b1;
      10: lnk <= !lnk;
      9: sym <= 1'b1;
      8: fc <= 1'b1;
      6: mdx <= !mdx;
      4: slp <= !slp;
      3: flp <= 1'b1;
      1: pol <= !pol;
      default: jab <= 1'b1;
    endcase
    @(posedge pclk);
    {anf, pg, anc, sym, fc, flp, jab} <= '0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // page 0 taken as selected; this block holds no page field
    apb(0, A_EN, 0, q); chk("en_rst", q, ENABLE_RST);
    apb(0, A_ST, 0, q); chk("st_rst", q, STATUS_RST);
    // reserved enable bits written as zero
    apb(1, A_EN, 16'hFF5B, q); apb(0, A_EN, 0, q); chk("en_rw", q, 16'hFF5B);
    apb(0, 8'h00, 0, q); chk("unmapped", {15'h0, slv}, 16'h0001);
    foreach (bits[i]) begin
      apb(1, A_EN, 16'hFF5B & ~(16'h1 << bits[i]), q);
      ev(bits[i], 0);
      chk("irq_off", {15'h0, irq}, 16'h0000);
      apb(0, A_ST, 0, q); chk("st_set", q, 16'h1 << bits[i]);
      apb(0, A_ST, 0, q); chk("st_clr", q, 16'h0000);
      apb(1, A_EN, 16'h1 << bits[i], q);
      ev(bits[i], 1);
      chk("irq_on", {15'h0, irq}, 16'h0001);
      apb(0, A_SUM, 0, q); chk("sum_on", q, 16'h0001);
      apb(0, A_ST, 0, q);
      apb(0, A_SUM, 0, q); chk("sum_off", q, 16'h0000);
    end
    for (int k = 2; k < 4; k++) begin
      ev(15, k);
      apb(0, A_ST, 0, q); chk("an_cause", q, 16'h8000);
    end
    @(posedge pclk);
    jab <= 1'b1;
    apb(0, A_ST, 0, q); apb(0, A_ST, 0, q); chk("jab_hold", q, 16'h0001);
    jab <= 1'b0;
    apb(0, A_ST, 0, q); apb(0, A_ST, 0, q); chk("jab_gone", q, 16'h0000);
    // soft reset clears status, keeps enable
    // write-one clear drops a latched bit; a present event still wins
    ev(12, 0);
    apb(1, A_CLR, 16'h1000, q); apb(0, A_ST, 0, q); chk("wr_clr", q, 16'h0000);
    @(posedge pclk);
    jab <= 1'b1;
    apb(1, A_CLR, 16'h0001, q); apb(0, A_ST, 0, q); chk("clr_set_win", q, 16'h0001);
    jab <= 1'b0;
    apb(0, A_ST, 0, q);
    ev(11, 0);
    @(posedge pclk);
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    apb(0, A_ST, 0, q); chk("st_srst", q, 16'h0000);
    apb(0, A_EN, 0, q); chk("en_keep", q, 16'h0001);
    // hardware reset in mid-run clears a latched bit and the enables
    ev(11, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_ST, 0, q); chk("st_hrst", q, STATUS_RST);
    apb(0, A_EN, 0, q); chk("en_hrst", q, ENABLE_RST);
    close_out();
  end
endmodule
